// ==== dmb_pkg.sv ====
// Shared constants and types for the debug mailbox command framer.
// Assumes a single 50 MHz clock domain and a byte-wide mailbox link.
package dmb_pkg;

	// Register offsets on the local software port.
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STAT     = 8'h04;
	localparam logic [7:0] OFF_CMD      = 8'h08;
	localparam logic [7:0] OFF_RSP_HDR  = 8'h0C;
	localparam logic [7:0] OFF_CRYPTO   = 8'h10;
	localparam logic [1:0] WIN_PARAM    = 2'h1;
	localparam logic [1:0] WIN_RSP_DATA = 2'h2;

	// Control and status field positions.
	localparam int CTRL_SEND_BIT   = 0;
	localparam int CTRL_VENDOR_BIT = 1;
	localparam int STAT_VENDOR_BIT = 4;
	localparam int STAT_AUTO_BIT   = 5;
	localparam int STAT_OVF_BIT    = 6;
	localparam int STAT_PEND_BIT   = 8;
	localparam int CRY_VENDOR_BIT  = 16;
	localparam int CRY_KNOWN_BIT   = 17;

	// Reset values.
	localparam logic        RST_VENDOR_EN = 1'b0;
	localparam logic [15:0] RST_RSP_WORD  = 16'h0000;

	// Command space.
	localparam int          CMD_VENDOR_BIT = 15;
	localparam logic [15:0] CMD_FIRST_STD  = 16'h0001;
	localparam logic [15:0] CMD_LAST_STD   = 16'h0005;
	localparam logic [15:0] STATUS_INVALID = 16'h7FFF;

	// Cryptosystem identifiers.
	localparam int          CRY_ID_VENDOR_BIT = 7;
	localparam logic [7:0]  CRY_LAST_STD      = 8'h09;
	localparam logic [7:0]  CRY_VENDOR_START  = 8'h80;

	// Public key type; the code equals the cryptosystem identifier.
	typedef enum logic [3:0] {
		KEY_NONE    = 4'h0,
		KEY_P256    = 4'h1,
		KEY_P521    = 4'h2,
		KEY_RSA3072 = 4'h3,
		KEY_RSA4096 = 4'h4,
		KEY_ED25519 = 4'h5,
		KEY_ED448   = 4'h6,
		KEY_SM2     = 4'h7,
		KEY_CMAC    = 4'h8,
		KEY_HMAC    = 4'h9
	} dmb_key_t;

	// Signature method bound to each key type.
	typedef enum logic [3:0] {
		SIG_NONE           = 4'h0,
		SIG_ECDSA_SHA256   = 4'h1,
		SIG_ECDSA_SHA512   = 4'h2,
		SIG_PSS_SHA256     = 4'h3,
		SIG_EDDSA_SHA512   = 4'h4,
		SIG_EDDSA_SHAKE256 = 4'h5,
		SIG_SM2_SM3        = 4'h6,
		SIG_CMAC_AES       = 4'h7,
		SIG_HMAC_SHA256    = 4'h8
	} dmb_sig_t;

	// Framer states.
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_PARAM   = 3'b001,
		ST_PENDING = 3'b010,
		ST_TX_HDR  = 3'b011,
		ST_TX_DATA = 3'b100
	} dmb_state_t;

endpackage : dmb_pkg

// ==== dmb_crypto_dec.sv ====
// Cryptosystem identifier decoder for the debug mailbox framer.
// Purely combinational; the instantiating module registers what it reads.
`timescale 1ns/1ns
module dmb_crypto_dec
(
	input  wire logic [7:0]        i_id,
	output dmb_pkg::dmb_key_t      o_key,
	output dmb_pkg::dmb_sig_t      o_sig,
	output logic                   o_known,
	output logic                   o_vendor
);

	// Vendor codes are flagged by the top bit and never map to a standard pair.
	always_comb
	begin
		o_vendor = i_id[dmb_pkg::CRY_ID_VENDOR_BIT];  // RQ1
		o_known  = 1'b1;
		o_key    = dmb_pkg::KEY_NONE;
		o_sig    = dmb_pkg::SIG_NONE;
		// One table gives both key and signature, so neither can disagree.
		case (i_id)  // RQ2 RQ3
			8'h01:   begin o_key = dmb_pkg::KEY_P256;    o_sig = dmb_pkg::SIG_ECDSA_SHA256;   end
			8'h02:   begin o_key = dmb_pkg::KEY_P521;    o_sig = dmb_pkg::SIG_ECDSA_SHA512;   end
			8'h03:   begin o_key = dmb_pkg::KEY_RSA3072; o_sig = dmb_pkg::SIG_PSS_SHA256;     end
			8'h04:   begin o_key = dmb_pkg::KEY_RSA4096; o_sig = dmb_pkg::SIG_PSS_SHA256;     end
			8'h05:   begin o_key = dmb_pkg::KEY_ED25519; o_sig = dmb_pkg::SIG_EDDSA_SHA512;   end
			8'h06:   begin o_key = dmb_pkg::KEY_ED448;   o_sig = dmb_pkg::SIG_EDDSA_SHAKE256; end
			8'h07:   begin o_key = dmb_pkg::KEY_SM2;     o_sig = dmb_pkg::SIG_SM2_SM3;        end
			8'h08:   begin o_key = dmb_pkg::KEY_CMAC;    o_sig = dmb_pkg::SIG_CMAC_AES;       end
			8'h09:   begin o_key = dmb_pkg::KEY_HMAC;    o_sig = dmb_pkg::SIG_HMAC_SHA256;    end
			default: o_known = 1'b0;
		endcase
	end

endmodule : dmb_crypto_dec

// ==== dmb_framer.sv ====
// Contract
// [RQ1] Cryptosystem ids are 8 bits; top bit means vendor.
// [RQ2] Codes 0x01..0x09 decode to the nine cryptosystems.
// [RQ3] Each key type has exactly one signature method.
// [RQ4] Packets are whole 32-bit words, bytes low first.
// [RQ5] Request header: command in bytes 0-1, count 2-3.
// [RQ6] Count gives parameter words; zero means header only.
// [RQ7] Command bit 15 marks a vendor command.
// [RQ8] Response header: status bytes 0-1, count 2-3, data.
// [RQ9] Reply answers latest request, no echo or sequence.
// [RQ10] Host requests only while idle.
// [RQ11] Response sent only while awaiting the reply.
// [RQ12] No other packet between request and response.
// [RQ13] Full response sent returns the protocol to idle.
// [RQ14] Target never sends unsolicited packets.
// [RQ15] No error correction, flow control or multiple commands.
// [RQ16] Unknown command answers status 0x7FFF, zero words.
// [RQ17] Read all declared parameter words before pending.
//
// Target-side framer: byte mailbox link towards the host, register port towards firmware.
// Assumes the link layer delivers bytes in order and error free.
`timescale 1ns/1ns
module dmb_framer
#(
	parameter int DEPTH = 4
)
(
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_byte,
	output logic             o_rx_ready,
	output logic             o_tx_valid,
	output logic [7:0]       o_tx_byte,
	input  wire logic        i_tx_ready,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [31:0]      o_rdata,
	output logic             o_pending
);

	localparam int IW = $clog2(DEPTH);

	// Buffer depth must fit the 16-word address windows; refused at elaboration.
	if (DEPTH < 2 || DEPTH > 16)
	begin : g_depth_check
		$error("dmb_framer: DEPTH must be 2 to 16");
	end

	typedef struct packed {
		dmb_pkg::dmb_state_t   st;
		logic [1:0]            bidx;
		logic [31:0]           acc;
		logic [15:0]           cmd;
		logic [15:0]           cnt;
		logic [15:0]           widx;
		logic [DEPTH-1:0][31:0] param;
		logic [15:0]           rsp_status;
		logic [15:0]           rsp_cnt;
		logic [DEPTH-1:0][31:0] rsp;
		logic [31:0]           txw;
		logic                  vendor_en;
		logic                  auto;
		logic                  ovf;
		logic [7:0]            crypto_id;
		logic [31:0]           rdata;
	} dmb_regs_t;

	dmb_regs_t s_ff;
	dmb_regs_t nxt_s;

	dmb_pkg::dmb_key_t cry_key;
	dmb_pkg::dmb_sig_t cry_sig;
	logic              cry_known;
	logic              cry_vendor;
	logic              rx_take;
	logic              tx_take;
	logic [31:0]       rx_word;
	logic              ovf_set;

	// Standard ids are recognised; vendor ids only when firmware enables them.
	function automatic logic cmd_known(input logic [15:0] c, input logic ven);
		if (c[dmb_pkg::CMD_VENDOR_BIT])  // RQ7
			cmd_known = ven;
		else
			cmd_known = (c >= dmb_pkg::CMD_FIRST_STD) && (c <= dmb_pkg::CMD_LAST_STD);
	endfunction : cmd_known

	// Buffered word at a 16-bit index; words beyond the buffer read as zero.
	function automatic logic [31:0] pick(input logic [DEPTH-1:0][31:0] buf_w,
		input logic [15:0] idx);
		pick = 32'h0000_0000;
		if (idx < 16'(DEPTH))
			pick = buf_w[idx[IW-1:0]];
	endfunction : pick

	dmb_crypto_dec u_dec
	(
		.i_id     (s_ff.crypto_id),
		.o_key    (cry_key),
		.o_sig    (cry_sig),
		.o_known  (cry_known),
		.o_vendor (cry_vendor)
	);

	// Link handshakes: receive only outside the pending exchange, send only inside it.
	assign o_rx_ready = (s_ff.st == dmb_pkg::ST_IDLE) || (s_ff.st == dmb_pkg::ST_PARAM);  // RQ12
	assign o_tx_valid = (s_ff.st == dmb_pkg::ST_TX_HDR) || (s_ff.st == dmb_pkg::ST_TX_DATA);  // RQ11 RQ14
	assign o_tx_byte  = s_ff.txw[7:0];  // RQ4
	assign o_rdata    = s_ff.rdata;
	assign o_pending  = (s_ff.st != dmb_pkg::ST_IDLE) && (s_ff.st != dmb_pkg::ST_PARAM);
	assign rx_take    = i_rx_valid && o_rx_ready;
	assign tx_take    = o_tx_valid && i_tx_ready;
	assign rx_word    = {i_rx_byte, s_ff.acc[31:8]};

	// A parameter word beyond the buffer raises the overflow flag in this cycle.
	assign ovf_set    = (s_ff.st == dmb_pkg::ST_PARAM) && rx_take && (s_ff.bidx == 2'h3) &&
		(s_ff.widx >= 16'(DEPTH));

	// Next-state logic for framing, sequencing and the register port.
	always_comb
	begin
		nxt_s = s_ff;
		// Bytes shift in from the top so that byte 0 ends in bits 7:0.
		if (rx_take)
		begin
			nxt_s.acc  = rx_word;  // RQ4
			nxt_s.bidx = s_ff.bidx + 2'h1;
		end
		case (s_ff.st)
			dmb_pkg::ST_IDLE:
			begin
				if (rx_take && s_ff.bidx == 2'h3)
				begin
					nxt_s.cmd  = rx_word[15:0];  // RQ5
					nxt_s.cnt  = rx_word[31:16];
					nxt_s.widx = 16'h0000;
					nxt_s.auto = !cmd_known(rx_word[15:0], s_ff.vendor_en);
					if (rx_word[31:16] != 16'h0000)
						nxt_s.st = dmb_pkg::ST_PARAM;  // RQ6
					else if (!cmd_known(rx_word[15:0], s_ff.vendor_en))
					begin
						nxt_s.st  = dmb_pkg::ST_TX_HDR;  // RQ16
						nxt_s.txw = {16'h0000, dmb_pkg::STATUS_INVALID};
					end
					else
						nxt_s.st = dmb_pkg::ST_PENDING;
				end
			end
			dmb_pkg::ST_PARAM:
			begin
				// Every declared word is taken; the surplus sets the overflow flag, not stored.
				if (rx_take && s_ff.bidx == 2'h3)
				begin
					if (s_ff.widx < 16'(DEPTH))
						nxt_s.param[s_ff.widx[IW-1:0]] = rx_word;
					else
						nxt_s.ovf = 1'b1;
					nxt_s.widx = s_ff.widx + 16'h0001;
					if (s_ff.widx + 16'h0001 == s_ff.cnt)  // RQ17
					begin
						if (s_ff.auto)
						begin
							nxt_s.st  = dmb_pkg::ST_TX_HDR;  // RQ16
							nxt_s.txw = {16'h0000, dmb_pkg::STATUS_INVALID};
						end
						else
							nxt_s.st = dmb_pkg::ST_PENDING;
					end
				end
			end
			dmb_pkg::ST_PENDING:
			begin
				// Firmware answers the request now held; nothing else can be queued.
				if (i_wr && i_addr == dmb_pkg::OFF_CTRL && i_wdata[dmb_pkg::CTRL_SEND_BIT])
				begin
					nxt_s.st  = dmb_pkg::ST_TX_HDR;  // RQ9 RQ11
					nxt_s.txw = {s_ff.rsp_cnt, s_ff.rsp_status};  // RQ8
				end
			end
			dmb_pkg::ST_TX_HDR,
			dmb_pkg::ST_TX_DATA:
			begin
				if (tx_take)
				begin
					nxt_s.txw  = {8'h00, s_ff.txw[31:8]};
					nxt_s.bidx = s_ff.bidx + 2'h1;
					if (s_ff.bidx == 2'h3)
					begin
						nxt_s.widx = (s_ff.st == dmb_pkg::ST_TX_HDR) ? 16'h0000 :
							s_ff.widx + 16'h0001;
						// The shift word has lost the count by now, so the held header decides.
						if ((s_ff.st == dmb_pkg::ST_TX_HDR &&
							(s_ff.auto || s_ff.rsp_cnt == 16'h0000)) ||
							(s_ff.st == dmb_pkg::ST_TX_DATA &&
							s_ff.widx + 16'h0001 == s_ff.rsp_cnt))
							nxt_s.st = dmb_pkg::ST_IDLE;  // RQ13
						else
						begin
							nxt_s.st  = dmb_pkg::ST_TX_DATA;  // RQ8
							nxt_s.txw = pick(s_ff.rsp, nxt_s.widx);
						end
					end
				end
			end
			default:
				nxt_s.st = dmb_pkg::ST_IDLE;
		endcase

		// Software writes; the hardware set of the overflow flag wins over its clear.
		if (i_wr)
		begin
			case (i_addr)
				dmb_pkg::OFF_CTRL:    nxt_s.vendor_en = i_wdata[dmb_pkg::CTRL_VENDOR_BIT];
				dmb_pkg::OFF_STAT:
					if (i_wdata[dmb_pkg::STAT_OVF_BIT] && !ovf_set)
						nxt_s.ovf = 1'b0;
				dmb_pkg::OFF_RSP_HDR:
				begin
					nxt_s.rsp_status = i_wdata[15:0];
					nxt_s.rsp_cnt    = i_wdata[31:16];
				end
				dmb_pkg::OFF_CRYPTO:  nxt_s.crypto_id = i_wdata[7:0];
				default:
					if (i_addr[7:6] == dmb_pkg::WIN_RSP_DATA && 32'(i_addr[5:2]) < DEPTH)
						nxt_s.rsp[i_addr[IW+1:2]] = i_wdata;
			endcase
		end

		// Read data stands only in the cycle after the strobe.
		nxt_s.rdata = 32'h0000_0000;
		if (i_rd)
		begin
			case (i_addr)
				dmb_pkg::OFF_CTRL:    nxt_s.rdata[dmb_pkg::CTRL_VENDOR_BIT] = s_ff.vendor_en;
				dmb_pkg::OFF_STAT:
				begin
					nxt_s.rdata[2:0]                     = s_ff.st;
					nxt_s.rdata[dmb_pkg::STAT_VENDOR_BIT] = s_ff.cmd[dmb_pkg::CMD_VENDOR_BIT];  // RQ7
					nxt_s.rdata[dmb_pkg::STAT_AUTO_BIT]  = s_ff.auto;
					nxt_s.rdata[dmb_pkg::STAT_OVF_BIT]   = s_ff.ovf;
					nxt_s.rdata[dmb_pkg::STAT_PEND_BIT]  = o_pending;
				end
				dmb_pkg::OFF_CMD:     nxt_s.rdata = {s_ff.cnt, s_ff.cmd};
				dmb_pkg::OFF_RSP_HDR: nxt_s.rdata = {s_ff.rsp_cnt, s_ff.rsp_status};
				dmb_pkg::OFF_CRYPTO:
				begin
					nxt_s.rdata[7:0]                    = s_ff.crypto_id;  // RQ1 RQ2 RQ3
					nxt_s.rdata[11:8]                   = cry_key;
					nxt_s.rdata[15:12]                  = cry_sig;
					nxt_s.rdata[dmb_pkg::CRY_VENDOR_BIT] = cry_vendor;
					nxt_s.rdata[dmb_pkg::CRY_KNOWN_BIT]  = cry_known;
				end
				default:
					if (i_addr[7:6] == dmb_pkg::WIN_PARAM && 32'(i_addr[5:2]) < DEPTH)
						nxt_s.rdata = s_ff.param[i_addr[IW+1:2]];
					else if (i_addr[7:6] == dmb_pkg::WIN_RSP_DATA && 32'(i_addr[5:2]) < DEPTH)
						nxt_s.rdata = s_ff.rsp[i_addr[IW+1:2]];
			endcase
		end
	end

	// State register; correction and flow control are left to the link.
	always_ff @(posedge i_clk or negedge i_arst_n)  // RQ15
	begin
		if (!i_arst_n)
		begin
			s_ff            <= '0;
			s_ff.st         <= dmb_pkg::ST_IDLE;
			s_ff.vendor_en  <= dmb_pkg::RST_VENDOR_EN;
			s_ff.rsp_status <= dmb_pkg::RST_RSP_WORD;
			s_ff.rsp_cnt    <= dmb_pkg::RST_RSP_WORD;
		end
		else
			s_ff <= nxt_s;
	end

	// The link never carries both directions at once.
	AST_NO_OVERLAP: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ12
		!(o_rx_ready && o_tx_valid))
		else $error("receive and transmit enabled together");

	// A send can only begin out of the pending state or an auto reply.
	AST_TX_SOLICITED: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ14
		$rose(o_tx_valid) |-> $past(s_ff.st) != dmb_pkg::ST_IDLE || $past(rx_take))
		else $error("transmission started without a request");

	// Firmware send from pending starts the header with its own status.
	AST_SEND_HDR: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ8 RQ11
		(s_ff.st == dmb_pkg::ST_PENDING && i_wr && i_addr == dmb_pkg::OFF_CTRL &&
		i_wdata[0]) |=> o_tx_valid && o_tx_byte == s_ff.rsp_status[7:0])
		else $error("response header does not start with status low byte");

	// A header-only unknown command is answered FF 7F 00 00.
	AST_UNKNOWN_REPLY: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ16
		(s_ff.st == dmb_pkg::ST_IDLE && rx_take && s_ff.bidx == 2'h3 &&
		rx_word[31:16] == 16'h0000 && !cmd_known(rx_word[15:0], s_ff.vendor_en))
		|=> s_ff.txw == 32'h0000_7FFF && o_tx_valid)
		else $error("unknown command not answered with invalid status");

	// The header fields land in the command register in byte order.
	AST_HDR_FIELDS: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ5
		(s_ff.st == dmb_pkg::ST_IDLE && rx_take && s_ff.bidx == 2'h3)
		|=> s_ff.cmd == {$past(s_ff.acc[23:16]), $past(s_ff.acc[15:8])} &&
		s_ff.cnt[15:8] == $past(i_rx_byte))
		else $error("request header fields misplaced");

	// The last declared parameter word ends reception.
	AST_PARAM_END: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ17 RQ6
		(s_ff.st == dmb_pkg::ST_PARAM && rx_take && s_ff.bidx == 2'h3 &&
		s_ff.widx + 16'h0001 == s_ff.cnt) |=> !o_rx_ready)
		else $error("reception continued past declared count");

	// A header-only reply returns to idle after four bytes.
	AST_BACK_IDLE: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ13
		(s_ff.st == dmb_pkg::ST_TX_HDR && tx_take && s_ff.bidx == 2'h3 &&
		(s_ff.auto || s_ff.rsp_cnt == 16'h0000)) |=> s_ff.st == dmb_pkg::ST_IDLE && o_rx_ready)
		else $error("exchange did not return to idle");

	// Vendor cryptosystem ids never decode as standard ones.
	AST_CRY_VENDOR: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ1
		s_ff.crypto_id >= dmb_pkg::CRY_VENDOR_START |-> cry_vendor && !cry_known)
		else $error("vendor cryptosystem decoded as standard");

	// Standard codes decode to a key whose code matches the id.
	AST_CRY_STD: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ2 RQ3
		(s_ff.crypto_id != 8'h00 && s_ff.crypto_id <= dmb_pkg::CRY_LAST_STD) |->
		cry_known && cry_key == s_ff.crypto_id[3:0] && cry_sig != dmb_pkg::SIG_NONE)
		else $error("standard cryptosystem decoded wrongly");

	// Status read reports the vendor bit of the held command.
	AST_VENDOR_FLAG: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ7
		(i_rd && i_addr == dmb_pkg::OFF_STAT) |=> o_rdata[4] == $past(s_ff.cmd[15]))
		else $error("vendor command flag wrong");

	// A firmware reply with data words goes on past its header.
	AST_TX_DATA: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ8
		(s_ff.st == dmb_pkg::ST_TX_HDR && !s_ff.auto &&
		s_ff.rsp_cnt != 16'h0000 && tx_take && s_ff.bidx == 2'h3)
		|=> s_ff.st == dmb_pkg::ST_TX_DATA)
		else $error("reply data words dropped after header");

	// A surplus parameter word always leaves the overflow flag set.
	AST_OVF_SET: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ17
		ovf_set |=> s_ff.ovf)
		else $error("overflow flag lost on a surplus word");

	// A reply byte stands unchanged until the host takes it.
	AST_TX_HOLD: assert property (@(posedge i_clk) disable iff (!i_arst_n)  // RQ8
		(o_tx_valid && !i_tx_ready) |=> o_tx_valid && $stable(o_tx_byte))
		else $error("reply byte changed before it was taken");

endmodule : dmb_framer

// ==== dmb_host_model.sv ====
// Host-side model of the byte mailbox link in front of the framer.
// Assumes one byte moves per clock edge where valid and ready are both high.
`timescale 1ns/1ns
module dmb_host_model
(
	input  wire logic       i_clk,
	input  wire logic       i_pending,
	input  wire logic       i_rx_ready,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_byte,
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_byte,
	output logic            o_tx_ready
);
	logic       slow = 1'b0;
	logic [7:0] rsp_q[$];
	// Quiet link at time zero.
	initial
	begin
		o_rx_valid = 1'b0;
		o_rx_byte  = 8'h00;
		o_tx_ready = 1'b0;
	end
	// Collect reply bytes; a slow host takes a byte only every other cycle.
	always @(posedge i_clk)
	begin
		if (i_tx_valid && o_tx_ready)
			rsp_q.push_back(i_tx_byte);
		o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
	end
	// Offer one byte and hold it until the framer takes it.
	task put_byte(input logic [7:0] b);
		o_rx_valid <= 1'b1;
		o_rx_byte  <= b;
		do @(posedge i_clk); while (!i_rx_ready);
	endtask : put_byte
	// Send a header and cnt parameter words, each word low byte first.
	task send_req(input logic [15:0] cmd, input logic [15:0] cnt, input logic [31:0] w[8]);
		@(posedge i_clk);
		while (i_pending) @(posedge i_clk);
		put_byte(cmd[7:0]);
		put_byte(cmd[15:8]);
		put_byte(cnt[7:0]);
		put_byte(cnt[15:8]);
		for (int i = 0; i < cnt; i++)
			for (int k = 0; k < 4; k++)
				put_byte(w[i][8*k +: 8]);
		// The released data line shows the inverse so a stale byte never looks valid.
		o_rx_valid <= 1'b0;
		o_rx_byte  <= ~o_rx_byte;
	endtask : send_req
endmodule : dmb_host_model

// ==== dmb_framer_tb_top.sv ====
// Self-checking bench for the debug mailbox command framer.
// Assumes the host model on the link; the bench acts as firmware.
`timescale 1ns/1ns
module dmb_framer_tb_top;
	localparam int DEPTH = 4;
	typedef struct packed {logic [7:0] id; logic [3:0] key; logic [3:0] sig; logic known;} dmb_row_t;
	logic        i_clk;
	logic        i_arst_n;
	logic        i_rx_valid;
	logic [7:0]  i_rx_byte;
	logic        o_rx_ready;
	logic        o_tx_valid;
	logic [7:0]  o_tx_byte;
	logic        i_tx_ready;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [31:0] o_rdata;
	logic        o_pending;
	logic [31:0] w[8];
	logic [7:0]  exp_q[$];
	logic [15:0] bad_cmds[3] = '{16'h0000, 16'h0006, 16'h8001};
	int          n_errors = 0;
	int          tests_run = 0;
	int          cycles = 0;
	dmb_row_t    rows[13] = '{'{8'h01,4'h1,4'h1,1'b1}, '{8'h02,4'h2,4'h2,1'b1},
		'{8'h03,4'h3,4'h3,1'b1}, '{8'h04,4'h4,4'h3,1'b1}, '{8'h05,4'h5,4'h4,1'b1},
		'{8'h06,4'h6,4'h5,1'b1}, '{8'h07,4'h7,4'h6,1'b1}, '{8'h08,4'h8,4'h7,1'b1},
		'{8'h09,4'h9,4'h8,1'b1}, '{8'h00,4'h0,4'h0,1'b0}, '{8'h0A,4'h0,4'h0,1'b0},
		'{8'h80,4'h0,4'h0,1'b0}, '{8'h85,4'h0,4'h0,1'b0}};

	dmb_framer #(.DEPTH(DEPTH)) dmb_framer_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .o_rx_ready(o_rx_ready),
		.o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_pending(o_pending));
	dmb_host_model dmb_host_model_inst (.i_clk(i_clk), .i_pending(o_pending),
		.i_rx_ready(o_rx_ready), .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte),
		.o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte), .o_tx_ready(i_tx_ready));

	// Free-running 50 MHz clock.
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// A hung run is cut short and counted as a mismatch.
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_errors++;
			complete_run();
		end
	end
	task complete_run;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One-cycle write strobe beside address and data.
	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : reg_wr
	// One-cycle read strobe; the data stand only in the following cycle.
	task reg_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk(what, exp, o_rdata);
	endtask : reg_chk
	task exp_word(input logic [31:0] x);
		for (int k = 0; k < 4; k++)
			exp_q.push_back(x[8*k +: 8]);
	endtask : exp_word
	// Wait for the whole reply, compare it byte by byte, then expect idle.
	task chk_rsp(input string what);
		int n;
		n = 0;
		while (dmb_host_model_inst.rsp_q.size() < exp_q.size() && n < 400)
		begin
			@(posedge i_clk);
			n++;
		end
		repeat (3) @(posedge i_clk);
		chk(what, exp_q.size(), dmb_host_model_inst.rsp_q.size());
		foreach (exp_q[k])
			chk(what, {24'h000000, exp_q[k]}, {24'h000000, dmb_host_model_inst.rsp_q[k]});
		@(negedge i_clk);
		chk("idle after reply", 32'h2, {30'h0, o_rx_ready, o_pending});
		exp_q.delete();
		dmb_host_model_inst.rsp_q.delete();
	endtask : chk_rsp
	task chk_wait;
		@(negedge i_clk);
		chk("awaiting reply", 32'h1, {30'h0, o_rx_ready, o_pending});
	endtask : chk_wait

	// Main sequence: cryptosystem table, then hand-written exchanges.
	initial
	begin
		i_arst_n = 1'b0;
		i_addr   = 8'h00;
		i_wdata  = 32'h0000_0000;
		i_wr     = 1'b0;
		i_rd     = 1'b0;
		w = '{32'hA1B2_C3D4, 32'h0F1E_2D3C, 32'h1122_3344, 32'h5566_7788,
			32'h99AA_BBCC, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
		repeat (12) @(posedge i_clk);
		chk("reset flags", 32'h4, {29'h0, o_rx_ready, o_tx_valid, o_pending});
		i_arst_n <= 1'b1;
		reg_chk("status after reset", dmb_pkg::OFF_STAT, 32'h0000_0000);
		foreach (rows[r])
		begin
			reg_wr(dmb_pkg::OFF_CRYPTO, {24'h000000, rows[r].id});
			reg_chk("crypto", dmb_pkg::OFF_CRYPTO, {14'h0000, rows[r].known, rows[r].id[7],
				rows[r].sig, rows[r].key, rows[r].id});
		end
		// Header-only request, two-word reply with a fast host.
		dmb_host_model_inst.send_req(16'h0001, 16'h0000, w);
		chk_wait();
		reg_chk("command", dmb_pkg::OFF_CMD, 32'h0000_0001);
		reg_chk("state", dmb_pkg::OFF_STAT, 32'h0000_0102);
		chk("no reply before send", 32'h0, {31'h0, o_tx_valid});
		for (int i = 0; i < DEPTH; i++)
			reg_wr(8'h80 + 8'(4 * i), w[i]);
		reg_wr(dmb_pkg::OFF_RSP_HDR, 32'h0002_1234);
		exp_word(32'h0002_1234);
		exp_word(w[0]);
		exp_word(w[1]);
		reg_wr(dmb_pkg::OFF_CTRL, 32'h0000_0001);
		chk_rsp("two word reply");
		// Two parameter words, empty reply to a slow host.
		dmb_host_model_inst.slow = 1'b1;
		dmb_host_model_inst.send_req(16'h0002, 16'h0002, w);
		chk_wait();
		reg_chk("param 0", 8'h40, w[0]);
		reg_chk("param 1", 8'h44, w[1]);
		reg_chk("command", dmb_pkg::OFF_CMD, 32'h0002_0002);
		reg_wr(dmb_pkg::OFF_RSP_HDR, 32'h0000_0001);
		reg_chk("reply header", dmb_pkg::OFF_RSP_HDR, 32'h0000_0001);
		exp_word(32'h0000_0001);
		reg_wr(dmb_pkg::OFF_CTRL, 32'h0000_0001);
		chk_rsp("slow reply");
		dmb_host_model_inst.slow = 1'b0;
		// Unknown and disabled vendor commands get the automatic reply.
		foreach (bad_cmds[c])
		begin
			dmb_host_model_inst.send_req(bad_cmds[c], 16'h0001, w);
			@(negedge i_clk);
			chk("auto reply start", 32'h1, {31'h0, o_tx_valid});
			exp_word(32'h0000_7FFF);
			chk_rsp("auto reply");
			reg_chk("command", dmb_pkg::OFF_CMD, {16'h0001, bad_cmds[c]});
		end
		// A header-only unknown command is answered straight from idle.
		dmb_host_model_inst.send_req(16'h0006, 16'h0000, w);
		exp_word(32'h0000_7FFF);
		chk_rsp("header-only auto reply");
		// Vendor command accepted once vendor commands are enabled.
		reg_wr(dmb_pkg::OFF_CTRL, 32'h0000_0002);
		reg_chk("control", dmb_pkg::OFF_CTRL, 32'h0000_0002);
		dmb_host_model_inst.send_req(16'h8001, 16'h0000, w);
		chk_wait();
		reg_chk("vendor state", dmb_pkg::OFF_STAT, 32'h0000_0112);
		reg_wr(dmb_pkg::OFF_RSP_HDR, 32'h0000_8000);
		exp_word(32'h0000_8000);
		reg_wr(dmb_pkg::OFF_CTRL, 32'h0000_0003);
		chk_rsp("vendor reply");
		// One word more than the buffer holds, reply one word past its end.
		reg_wr(dmb_pkg::OFF_CTRL, 32'h0000_0000);
		dmb_host_model_inst.send_req(16'h0003, 16'(DEPTH + 1), w);
		chk_wait();
		reg_chk("overflow", dmb_pkg::OFF_STAT, 32'h0000_0142);
		reg_wr(dmb_pkg::OFF_STAT, 32'h0000_0040);
		reg_chk("overflow clear", dmb_pkg::OFF_STAT, 32'h0000_0102);
		reg_chk("last param", 8'h4C, w[3]);
		reg_wr(dmb_pkg::OFF_RSP_HDR, 32'h0005_0000);
		exp_word(32'h0005_0000);
		for (int i = 0; i < DEPTH; i++)
			exp_word(w[i]);
		exp_word(32'h0000_0000);
		reg_wr(dmb_pkg::OFF_CTRL, 32'h0000_0001);
		chk_rsp("long reply");
		// Send while idle does nothing; unmapped places read zero.
		reg_wr(dmb_pkg::OFF_CTRL, 32'h0000_0001);
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
		chk("no unsolicited reply", 32'h0, {31'h0, o_tx_valid});
		reg_wr(8'h20, 32'hFFFF_FFFF);
		reg_chk("unmapped", 8'h20, 32'h0000_0000);
		reg_chk("param past depth", 8'h50, 32'h0000_0000);
		complete_run();
	end
endmodule : dmb_framer_tb_top
